// ==== hdl/picb_consts.svh ====
// Constants for the peripheral interrupt control bank.
// Assumes an APB master on a 40 MHz clock and one-cycle event strobes from peripherals.
//
// Behaviour
// - Control bits 7 and 6 hold the source's two-bit priority level, 0 to 3.
// - Control bit 1 enables the source; zero blocks its request to the CPU.
// - Control bit 0 is the request flag, set when the source raises an event.
// - One control register per source, consecutive indices timer 7 through timer 8 compare-2.
`ifndef PICB_CONSTS_SVH
`define PICB_CONSTS_SVH

`define PICB_NUM_SRC          11
`define PICB_SLOT_W           4
`define PICB_IDX_W            14
`define PICB_ADDR_W           16

// Register indices; byte address is four times the index
`define PICB_IDX_TIMER7       14'h3fed
`define PICB_IDX_TIMER7_CMP2  14'h3fee
`define PICB_IDX_SERIAL0_RX   14'h3fef
`define PICB_IDX_SERIAL0_TX   14'h3ff0
`define PICB_IDX_SERIAL1_RX   14'h3ff1
`define PICB_IDX_SERIAL1_TX   14'h3ff2
`define PICB_IDX_SERIAL3      14'h3ff3
`define PICB_IDX_ADC_DONE     14'h3ff4
`define PICB_IDX_SERIAL4      14'h3ff5
`define PICB_IDX_TIMER8       14'h3ff6
`define PICB_IDX_TIMER8_CMP2  14'h3ff7
`define PICB_IDX_EVT_STATUS   14'h3ff8
`define PICB_IDX_EVT_MASK     14'h3ff9

// Source positions in the event and request vectors
`define PICB_SRC_TIMER7       0
`define PICB_SRC_TIMER7_CMP2  1
`define PICB_SRC_SERIAL0_RX   2
`define PICB_SRC_SERIAL0_TX   3
`define PICB_SRC_SERIAL1_RX   4
`define PICB_SRC_SERIAL1_TX   5
`define PICB_SRC_SERIAL3      6
`define PICB_SRC_ADC_DONE     7
`define PICB_SRC_SERIAL4      8
`define PICB_SRC_TIMER8       9
`define PICB_SRC_TIMER8_CMP2  10

// Control register fields; register reset values
`define PICB_LVL_HI           7
`define PICB_LVL_LO           6
`define PICB_ENABLE_BIT       1
`define PICB_REQUEST_BIT      0
`define PICB_CTRL_RESET       8'h00
`define PICB_MASK_RESET       11'h000
`define PICB_STATUS_RESET     11'h000
`define PICB_RSVD_ZERO        4'h0

`endif

// ==== hdl/picb_pkg.sv ====
// Types shared by the interrupt control bank modules.
// Assumes picb_consts.svh for the source vector width; level and control widths are fixed here.
`include "picb_consts.svh"

package picb_pkg;

    typedef logic [1:0]                  picb_level_t;
    typedef logic [7:0]                  picb_ctrl_t;
    typedef logic [`PICB_NUM_SRC-1:0]    picb_src_vec_t;

    typedef enum logic [1:0] {
        PICB_ST_IDLE = 2'b01,
        PICB_ST_RESP = 2'b10
    } picb_apb_state_t;

endpackage

// ==== hdl/picb_src_if.sv ====
// Link between the bank's bus side and one source control slot.
// Assumes one instance per source, all on the bank clock.
interface picb_src_if;

    logic               wr_en;
    picb_pkg::picb_ctrl_t wr_data;
    logic               evt;
    picb_pkg::picb_ctrl_t ctrl;

    modport bank (
        output wr_en,
        output wr_data,
        output evt,
        input  ctrl
    );

    modport slot (
        input  wr_en,
        input  wr_data,
        input  evt,
        output ctrl
    );

endinterface

// ==== hdl/picb_src_slot.sv ====
// One per-source interrupt control register.
// Assumes wr_en and evt are single-cycle pulses on clk.
`include "picb_consts.svh"

module picb_src_slot (
    input wire logic   clk,
    input wire logic   rst_n,
    picb_src_if.slot   port
);

    picb_pkg::picb_ctrl_t ctrl_q;
    picb_pkg::picb_ctrl_t wr_value;
    picb_pkg::picb_ctrl_t next_ctrl;

    // Reserved bits never store
    assign wr_value = {port.wr_data[`PICB_LVL_HI:`PICB_LVL_LO], `PICB_RSVD_ZERO,
                       port.wr_data[`PICB_ENABLE_BIT:`PICB_REQUEST_BIT]};

    always_comb
    begin
        next_ctrl = ctrl_q;
        if (port.wr_en)
        begin
            next_ctrl = wr_value;
        end
        // Event beats a same-cycle clear of the flag
        if (port.evt)
        begin
            next_ctrl[`PICB_REQUEST_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `PICB_CTRL_RESET;
        else
            ctrl_q <= next_ctrl;
    end

    assign port.ctrl = ctrl_q;

endmodule

// ==== hdl/picb_top.sv ====
// Peripheral interrupt control bank: eleven source control registers on APB,
// sticky event status with mask and one level interrupt, gated requests to the CPU.
// Assumes a single 40 MHz clock, synchronous inputs and one-cycle event strobes.
`include "picb_consts.svh"

module picb_top (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [`PICB_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [`PICB_NUM_SRC-1:0]   src_event,
    output logic      [`PICB_NUM_SRC-1:0]   cpu_req,
    output logic      [2*`PICB_NUM_SRC-1:0] cpu_level,
    output logic                            irq
);

    picb_pkg::picb_apb_state_t state;
    picb_pkg::picb_apb_state_t next_state;

    picb_pkg::picb_src_vec_t   evt_status;
    picb_pkg::picb_src_vec_t   evt_mask;
    picb_pkg::picb_src_vec_t   next_status;
    picb_pkg::picb_src_vec_t   next_mask;
    picb_pkg::picb_src_vec_t   status_clr;
    picb_pkg::picb_src_vec_t   strb_vec;

    picb_pkg::picb_ctrl_t      ctrl_rd [`PICB_NUM_SRC];

    // Address decode
    wire [`PICB_IDX_W-1:0]     idx;
    wire [`PICB_IDX_W-1:0]     idx_off;
    wire [`PICB_SLOT_W-1:0]    slot_sel;
    wire                       aligned;
    wire                       in_bank;
    wire                       hit_status;
    wire                       hit_mask;
    wire                       mapped;

    // Transfer phases
    wire                       access;
    wire                       first_access;
    wire                       complete;
    wire                       wr_commit;
    wire                       ctrl_wr;
    wire                       status_wr;
    wire                       mask_wr;

    wire [31:0]                rd_word;
    wire [7:0]                 rd_ctrl;
    wire [`PICB_NUM_SRC-1:0]   gated_req;
    wire                       next_irq;

    assign idx          = paddr[`PICB_ADDR_W-1:2];
    assign aligned      = (paddr[1:0] == 2'h0);
    assign idx_off      = idx - `PICB_IDX_TIMER7;
    assign slot_sel     = idx_off[`PICB_SLOT_W-1:0];
    assign in_bank      = aligned && (idx >= `PICB_IDX_TIMER7) && (idx <= `PICB_IDX_TIMER8_CMP2);
    assign hit_status   = aligned && (idx == `PICB_IDX_EVT_STATUS);
    assign hit_mask     = aligned && (idx == `PICB_IDX_EVT_MASK);
    assign mapped       = in_bank || hit_status || hit_mask;

    // One wait state: pready rises in the second access cycle
    assign access       = psel && penable;
    assign first_access = access && (state == picb_pkg::PICB_ST_IDLE);
    assign complete     = access && (state == picb_pkg::PICB_ST_RESP);
    assign wr_commit    = complete && pwrite && mapped;
    assign ctrl_wr      = wr_commit && in_bank && pstrb[0];
    assign status_wr    = wr_commit && hit_status;
    assign mask_wr      = wr_commit && hit_mask;

    always_comb
    begin
        case (state)
            picb_pkg::PICB_ST_IDLE:
            begin
                next_state = first_access ? picb_pkg::PICB_ST_RESP : picb_pkg::PICB_ST_IDLE;
            end
            picb_pkg::PICB_ST_RESP:
            begin
                next_state = picb_pkg::PICB_ST_IDLE;
            end
            default:
            begin
                next_state = picb_pkg::PICB_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= picb_pkg::PICB_ST_IDLE;
        else
            state <= next_state;
    end

    // Per-source control slots
    genvar gi;
    generate
        for (gi = 0; gi < `PICB_NUM_SRC; gi++)
        begin : g_src
            picb_src_if src_link ();

            assign src_link.wr_en   = ctrl_wr && (int'(slot_sel) == gi);
            assign src_link.wr_data = pwdata[7:0];
            assign src_link.evt     = src_event[gi];
            assign ctrl_rd[gi]      = src_link.ctrl;
            assign gated_req[gi]    = src_link.ctrl[`PICB_REQUEST_BIT] && src_link.ctrl[`PICB_ENABLE_BIT];

            picb_src_slot u_slot (
                .clk   (clk),
                .rst_n (rst_n),
                .port  (src_link.slot)
            );

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cpu_req[gi]          <= 1'b0;
                    cpu_level[2*gi +: 2] <= 2'h0;
                end
                else
                begin
                    cpu_req[gi]          <= gated_req[gi];
                    cpu_level[2*gi +: 2] <= src_link.ctrl[`PICB_LVL_HI:`PICB_LVL_LO];
                end
            end
        end
    endgenerate

    // Byte lanes for the 11-bit status and mask words
    assign strb_vec = {{(`PICB_NUM_SRC-8){pstrb[1]}}, {8{pstrb[0]}}};

    // Write one to clear; a new event in the same cycle wins
    assign status_clr = status_wr ? (pwdata[`PICB_NUM_SRC-1:0] & strb_vec) : '0;

    always_comb
    begin
        next_status = (evt_status & ~status_clr) | src_event;
        next_mask   = evt_mask;
        if (mask_wr)
        begin
            next_mask = (evt_mask & ~strb_vec) | (pwdata[`PICB_NUM_SRC-1:0] & strb_vec);
        end
    end

    assign next_irq = |(next_status & next_mask);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_status <= `PICB_STATUS_RESET;
            evt_mask   <= `PICB_MASK_RESET;
            irq        <= 1'b0;
        end
        else
        begin
            evt_status <= next_status;
            evt_mask   <= next_mask;
            irq        <= next_irq;
        end
    end

    // Read selection; reserved bits and upper word read zero
    assign rd_ctrl = ctrl_rd[slot_sel];
    assign rd_word = in_bank    ? {24'h000000, rd_ctrl} :
                     hit_status ? {21'h000000, evt_status} :
                     hit_mask   ? {21'h000000, evt_mask} :
                                  32'h00000000;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= first_access;
            pslverr <= first_access && !mapped;
            if (first_access && !pwrite)
                prdata <= rd_word;
            else if (complete)
                prdata <= 32'h00000000;
        end
    end

endmodule

// ==== tb/picb_monitor.sv ====
// Port checker for the interrupt control bank.
// Assumes binding to picb_top; one clock, async low reset.
module picb_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [10:0] cpu_req,
    input wire logic [21:0] cpu_level,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wr_d;
    wire        recent_wr = |wr_d;
    // Write completions of the last three cycles
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_d <= 3'h0;
        else
            wr_d <= {wr_d[1:0], pready & pwrite};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    acc_wait_a: assert property (psel && penable && !pready |=> pready && !$past(pready))
        else $error("answer not one cycle after access");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("refused access with data");
    rsvd_zero_a: assert property (pready && paddr[15:2] <= 14'h3ff7 |-> prdata[31:8] == 0 && prdata[5:2] == 0)
        else $error("reserved control bits not zero");
    level_cause_a: assert property ($changed(cpu_level) |-> recent_wr)
        else $error("level moved without a write");
    req_drop_a: assert property (|($past(cpu_req) & ~cpu_req) |-> recent_wr)
        else $error("request dropped without a write");
    irq_fall_a: assert property ($fell(irq) |-> recent_wr)
        else $error("interrupt fell without a write");
endmodule

bind picb_top picb_monitor i_mon (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .cpu_req, .cpu_level, .irq);

// ==== tb/picb_far_side.sv ====
// Peripheral event sources and CPU acceptance.
// Assumes fire is held one cycle per event.
module picb_far_side (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [10:0] fire,
    input wire logic [10:0] cpu_req,
    input wire logic        global_maskable_irq_enable,
    output logic     [10:0] src_event,
    output logic     [10:0] taken
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            src_event <= 11'h000;
        else
            src_event <= fire;
    end
    // CPU takes requests only with global enable on
    assign taken = global_maskable_irq_enable ? cpu_req : 11'h000;
endmodule

// ==== tb/picb_top_bench.sv ====
// Bench: APB register tests and event traffic for the bank.
// Assumes picb_top, picb_far_side and picb_monitor compiled.
`include "picb_consts.svh"
module picb_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        global_maskable_irq_enable;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] fire, src_event, cpu_req, taken;
    logic [21:0] cpu_level, lvl;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    picb_top i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
        .prdata, .pready, .pslverr, .src_event, .cpu_req, .cpu_level, .irq);
    picb_far_side i_far (.clk, .rst_n, .fire, .cpu_req, .global_maskable_irq_enable,
        .src_event, .taken);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
        if (w)
            global_maskable_irq_enable <= 1'b0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic complete_run;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            complete_run;
        end
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, fire, global_maskable_irq_enable} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            apb(0, `PICB_IDX_TIMER7 + 14'(i), 0);
            check("ctrl reset", rd, 0);
            apb(1, `PICB_IDX_TIMER7 + 14'(i), {2'(i), 6'h3e});
            apb(0, `PICB_IDX_TIMER7 + 14'(i), 0);
            check("ctrl level", rd, {2'(i), 6'h02});
            lvl[2*i +: 2] = 2'(i);
        end
        check("level out", cpu_level, lvl);
        check("no request", cpu_req, 0);
        fire <= 11'h7ff;
        @(posedge clk);
        fire <= 11'h000;
        repeat (4) @(posedge clk);
        check("request out", cpu_req, 11'h7ff);
        check("irq masked", irq, 0);
        global_maskable_irq_enable <= 1'b1;
        @(posedge clk);
        check("taken", taken, 11'h7ff);
        apb(0, `PICB_IDX_SERIAL4, 0);
        check("flag set", rd, 8'h03);
        apb(1, `PICB_IDX_TIMER7, 8'h01);
        repeat (3) @(posedge clk);
        check("disabled", cpu_req[0], 0);
        apb(1, `PICB_IDX_EVT_MASK, 11'h400);
        repeat (3) @(posedge clk);
        check("irq on", irq, 1);
        apb(1, `PICB_IDX_EVT_STATUS, 11'h400);
        repeat (3) @(posedge clk);
        check("irq cleared", irq, 0);
        apb(0, `PICB_IDX_EVT_STATUS, 0);
        check("status", rd, 11'h3ff);
        // Event strobe lands on the edge that writes the flag to zero
        fork
            apb(1, `PICB_IDX_TIMER7_CMP2, 8'h02);
            begin
                @(posedge clk);
                fire <= 11'h002;
                @(posedge clk);
                fire <= 11'h000;
            end
        join
        apb(0, `PICB_IDX_TIMER7_CMP2, 0);
        check("event beats clear", rd, 8'h03);
        check("request kept", cpu_req[1], 1);
        apb(0, 14'h3ffa, 0);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        complete_run;
    end
endmodule
